// ---- fosr_bus_cycle.v ----
// Purpose: one asynchronous flash bus cycle, read or write
// Assumes: pins driven from flops, strobes held a fixed count
// Notes: each read drops both enables, so the latch refreshes
`timescale 1ns/1ps
`include "fosr_regs.vh"
module fosr_bus_cycle #(
    parameter AW = 21,
    parameter DW = 16,
    parameter PULSE = `FOSR_PULSE_CYC
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Request
    input wire start,
    input wire is_write,
    input wire [AW-1:0] addr,
    input wire [DW-1:0] wdata,
    output reg done,
    output reg [DW-1:0] rdata,
    // Flash pins
    output reg [AW-1:0] f_addr,
    output reg f_ce_n,
    output reg f_oe_n,
    output reg f_we_n,
    output reg [DW-1:0] f_dq_o,
    output reg f_dq_oe,
    input wire [DW-1:0] f_dq_i
);
    // Pulse counter and busy flag
    reg [7:0] cnt;
    reg busy;
    reg wr;

    // ****************************************
    // Cycle sequencer
    // ****************************************
    // Enables rise between cycles so the device recaptures status
    always @(posedge clk) begin
        done <= 1'b0;
        if (srst) begin
            cnt <= 8'h00;
            busy <= 1'b0;
            wr <= 1'b0;
            rdata <= {DW{1'b0}};
            f_addr <= {AW{1'b0}};
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            f_dq_o <= {DW{1'b0}};
            f_dq_oe <= 1'b0;
        end else if (!busy) begin
            if (start) begin
                // Falling enable edge opens a fresh capture
                busy <= 1'b1;
                wr <= is_write;
                cnt <= 8'h00;
                f_addr <= addr;
                f_ce_n <= 1'b0;
                f_oe_n <= is_write;
                f_we_n <= ~is_write;
                f_dq_o <= wdata;
                f_dq_oe <= is_write;
            end
        end else if (cnt == PULSE[7:0]) begin
            // Sample read data at end of strobe
            if (!wr) begin
                rdata <= f_dq_i;
            end
            busy <= 1'b0;
            done <= 1'b1;
            f_ce_n <= 1'b1;
            f_oe_n <= 1'b1;
            f_we_n <= 1'b1;
            f_dq_oe <= 1'b0;
        end else begin
            cnt <= cnt + 8'h01;
        end
    end
endmodule // fosr_bus_cycle

// ---- fosr_flash_model.sv ----
// Purpose: behavioural flash status register facing the host
// Assumes: the test sets the core status byte on dev_stat
// Notes: released data lines show the inverse of the last byte
`timescale 1ns/1ps
module fosr_flash_model (
    // Flash pins
    input wire [15:0] f_dq_o,
    input wire f_ce_n,
    input wire f_oe_n,
    input wire f_we_n,
    output wire [15:0] f_dq_i,
    // Test control
    input wire [7:0] dev_stat
);
    // ****************************************
    // Status latch
    // ****************************************
    reg [7:0] sticky = 8'h00; // Error flags start clear
    reg [7:0] latched = 8'h81; // Byte held for the bus
    // Capture on either enable falling; address plays no part
    always @(negedge f_ce_n or negedge f_oe_n) begin
        sticky = sticky | (dev_stat & 8'h3A);
        // Reserved bit forced high so an unmasked host shows it
        latched = (dev_stat & 8'hC4) | sticky | 8'h01;
    end
    // Clear-status byte drops the sticky flags
    always @(posedge f_we_n) begin
        if (f_dq_o[7:0] == 8'h50) begin
            sticky = 8'h00;
        end
    end
    // Drive only while selected, else the inverse of the latched byte
    assign f_dq_i = (!f_ce_n && !f_oe_n) ? {8'h00, latched} : ~{8'h00, latched};
endmodule // fosr_flash_model

// ---- fosr_host.v ----
// Purpose: host controller reading the flash status register
// Assumes: software issues one operation at a time through CTRL
// Notes: poll repeats status reads until the ready bit is high or POLL_LIMIT + 1 reads have gone
`timescale 1ns/1ps
`include "fosr_regs.vh"
module fosr_host #(
    parameter AW = 21,
    parameter DW = 16,
    parameter POLL_LIMIT = `FOSR_ERASE_SUSP_CYC
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Software port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output reg [31:0] reg_rdata,
    // Flash pins
    output wire [AW-1:0] f_addr,
    output wire f_ce_n,
    output wire f_oe_n,
    output wire f_we_n,
    output wire [DW-1:0] f_dq_o,
    output wire f_dq_oe,
    input wire [DW-1:0] f_dq_i
);
    // ****************************************
    // States
    // ****************************************
    localparam ST_IDLE = 3'h0;
    localparam ST_CMD = 3'h1;
    localparam ST_RD = 3'h2;
    localparam ST_CHECK = 3'h3;
    localparam ST_WAIT = 3'h4;

    // ****************************************
    // Operation overview
    // ****************************************
    // Software writes an op code into CTRL while STAT.busy is low.
    // Op codes and what each one puts on the flash pins:
    //   read status  - command cycle with the read-status byte, then
    //                  one read cycle; the byte lands in FSTAT
    //   write data   - one write cycle carrying DATA at ADDR
    //   read         - one read cycle at ADDR; the word lands in RDATA
    //   poll         - like read status, but reads repeat until the
    //                  ready bit is high or POLL_LIMIT + 1 reads have gone
    //   clear status - command cycle with the clear-status byte; the
    //                  error bits kept in FSTAT are dropped as well
    //
    // State walk for a poll:
    //   ST_IDLE  -> CTRL write seen, command cycle requested
    //   ST_CMD   -> command cycle done, first status read requested
    //   ST_CHECK -> read done; ready or the limit ends the op, busy below the limit goes to ST_WAIT
    //   ST_WAIT  -> one idle cycle, then a new read is requested
    //
    // Every status read is a full cycle of its own. The device only
    // refreshes its status latch on a falling enable, so holding the
    // enables low and sampling again would return the same byte
    // forever. The cost is roughly fourteen clocks per status read.
    //
    // POLL_LIMIT counts reads, not clocks. Its default matches the
    // longest suspend wait divided by the clock period, which is
    // generous: each read takes many clocks, so the real wait is
    // longer than the device needs. A shorter limit risks a false
    // timeout on a slow erase; a longer one only delays the report.
    //
    // STAT bits:
    //   bit 0 busy    - an op is in flight, CTRL writes are ignored
    //   bit 1 timeout - the last op was a poll that gave up with the device busy
    //   bit 2 fail    - the last idle byte had an error flag set
    //
    // Error flags in the device stay set until cleared, so a stale
    // flag would make every later op look failed. Software should
    // run clear status after reading a failure, before the next op.
    //
    // CTRL writes during busy are dropped without a sign. Software
    // must poll STAT.busy first; queueing was left out to keep the
    // sequencer small, since the register port never waits.
    //
    // ADDR and DATA may be written at any time. They are copied into
    // the cycle request only when an op starts, so changing them
    // during an op does not disturb the cycle on the pins.
    //
    // Limitations:
    //   no erase or program algorithms, only single cycles
    //   no suspend or resume sequences of its own
    //   the status byte is taken from the low data byte only

    // Software registers
    reg [AW-1:0] op_addr;
    reg [DW-1:0] op_data;
    reg [2:0] op;
    reg [7:0] fstat;     // Last status byte, bit 0 masked
    reg [DW-1:0] last_rd;
    reg busy;
    reg timeout;
    reg fail;
    // Sequencer state
    reg [2:0] state;
    // Reads done in this op; wide so the limit never wraps
    reg [31:0] wait_cnt;
    // Sub-cycle request
    reg cyc_start;
    reg cyc_write;
    reg [AW-1:0] cyc_addr;
    reg [DW-1:0] cyc_wdata;
    // Sub-cycle answer
    wire cyc_done;
    wire [DW-1:0] cyc_rdata;
    // Low byte with the reserved bit cleared
    wire [7:0] masked;

    // Reserved bit masked from every status byte kept in FSTAT
    assign masked = cyc_rdata[7:0] & `FOSR_STATUS_MASK;

    // ****************************************
    // Status byte decode
    // ****************************************
    // Ready bit of the byte just read
    wire st_ready;
    // Any sticky error flag in the byte just read
    wire st_error;
    // Byte kept for software, suspend flags hidden while busy
    wire [7:0] st_view;
    assign st_ready = masked[`FOSR_BIT_READY];
    assign st_error = |(masked & `FOSR_ERROR_MASK);
    // Suspend flags mean nothing until the device is idle
    // A busy byte could still show a stale suspend, so it is dropped
    assign st_view = masked & {1'b1, st_ready, 3'b111, st_ready, 2'b11};

    // One flash cycle engine; the pins come straight from its flops
    fosr_bus_cycle #(
        .AW(AW),
        .DW(DW)
    ) u_cyc (
        .clk(clk),
        .srst(srst),
        .start(cyc_start),
        .is_write(cyc_write),
        .addr(cyc_addr),
        .wdata(cyc_wdata),
        .done(cyc_done),
        .rdata(cyc_rdata),
        .f_addr(f_addr),
        .f_ce_n(f_ce_n),
        .f_oe_n(f_oe_n),
        .f_we_n(f_we_n),
        .f_dq_o(f_dq_o),
        .f_dq_oe(f_dq_oe),
        .f_dq_i(f_dq_i)
    );

    // ****************************************
    // Software register read
    // ****************************************
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 32'h0000_0000;
        end else if (reg_rd) begin
            case (reg_addr)
                `FOSR_REG_ADDR: reg_rdata <= {{(32-AW){1'b0}}, op_addr};
                `FOSR_REG_DATA: reg_rdata <= {{(32-DW){1'b0}}, op_data};
                `FOSR_REG_STAT: reg_rdata <= {29'h0, fail, timeout, busy};
                `FOSR_REG_FSTAT: reg_rdata <= {24'h0, fstat};
                `FOSR_REG_RDATA: reg_rdata <= {{(32-DW){1'b0}}, last_rd};
                default: reg_rdata <= 32'h0000_0000;
            endcase
        end else begin
            // Data stands one cycle only, zero otherwise
            reg_rdata <= 32'h0000_0000;
        end
    end

    // ****************************************
    // Operation sequencer
    // ****************************************
    // Only one flash cycle is in flight; software writes to CTRL
    // while busy are dropped rather than queued
    always @(posedge clk) begin
        cyc_start <= 1'b0;
        if (srst) begin
            op_addr <= {AW{1'b0}};
            op_data <= {DW{1'b0}};
            op <= `FOSR_OP_NONE;
            fstat <= 8'h00;
            last_rd <= {DW{1'b0}};
            busy <= 1'b0;
            timeout <= 1'b0;
            fail <= 1'b0;
            state <= ST_IDLE;
            wait_cnt <= 32'h0;
            cyc_write <= 1'b0;
            cyc_addr <= {AW{1'b0}};
            cyc_wdata <= {DW{1'b0}};
        end else begin
            if (reg_wr && reg_addr == `FOSR_REG_ADDR) begin
                op_addr <= reg_wdata[AW-1:0];
            end
            if (reg_wr && reg_addr == `FOSR_REG_DATA) begin
                op_data <= reg_wdata[DW-1:0];
            end
            case (state)
                ST_IDLE: begin
                    if (reg_wr && reg_addr == `FOSR_REG_CTRL &&
                        reg_wdata[2:0] != `FOSR_OP_NONE) begin
                        op <= reg_wdata[2:0];
                        busy <= 1'b1;
                        timeout <= 1'b0;
                        wait_cnt <= 32'h0;
                        cyc_start <= 1'b1;
                        cyc_addr <= op_addr;
                        case (reg_wdata[2:0])
                            `FOSR_OP_READ_STAT, `FOSR_OP_POLL: begin
                                // Read-status command first
                                cyc_write <= 1'b1;
                                cyc_wdata <= `FOSR_CMD_READ_STATUS;
                                state <= ST_CMD;
                            end
                            `FOSR_OP_CLEAR: begin
                                // Clear flags before next command
                                cyc_write <= 1'b1;
                                cyc_wdata <= `FOSR_CMD_CLEAR_STATUS;
                                state <= ST_CMD;
                            end
                            `FOSR_OP_WRITE: begin
                                cyc_write <= 1'b1;
                                cyc_wdata <= op_data;
                                state <= ST_CMD;
                            end
                            default: begin
                                cyc_write <= 1'b0;
                                state <= ST_RD;
                            end
                        endcase
                    end
                end
                ST_CMD: begin
                    if (cyc_done) begin
                        if (op == `FOSR_OP_READ_STAT || op == `FOSR_OP_POLL) begin
                            cyc_start <= 1'b1;
                            cyc_write <= 1'b0;
                            state <= ST_CHECK;
                        end else begin
                            if (op == `FOSR_OP_CLEAR) begin
                                // Clear drops the error bits software still sees
                                fstat <= fstat & ~`FOSR_ERROR_MASK;
                                fail <= 1'b0;
                            end
                            busy <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_RD: begin
                    if (cyc_done) begin
                        // Whole word kept; during an op it is the status byte
                        last_rd <= cyc_rdata;
                        busy <= 1'b0;
                        state <= ST_IDLE;
                    end
                end
                ST_CHECK: begin
                    if (cyc_done) begin
                        // Suspend flags kept only from an idle byte
                        fstat <= st_view;
                        wait_cnt <= wait_cnt + 32'h1;
                        // Poll ready bit; others trusted only once idle
                        if (op == `FOSR_OP_POLL && !st_ready) begin
                            // Reads counted from zero, so the limit allows one more
                            if (wait_cnt >= POLL_LIMIT) begin
                                // Give up; the byte kept shows the device still busy
                                timeout <= 1'b1;
                                busy <= 1'b0;
                                state <= ST_IDLE;
                            end else begin
                                // Let the enables rise before the next read
                                state <= ST_WAIT;
                            end
                        end else begin
                            // Idle: error flags decide success
                            fail <= st_ready & st_error;
                            busy <= 1'b0;
                            state <= ST_IDLE;
                        end
                    end
                end
                ST_WAIT: begin
                    // New enable toggle for a fresh status
                    cyc_start <= 1'b1;
                    cyc_write <= 1'b0;
                    state <= ST_CHECK;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // fosr_host

// ---- fosr_host_sva.sv ----
// Purpose: pin and register-port checks for the flash status host
// Assumes: one clock domain, srst synchronous active high
// Notes: strobe figures follow the 11-cycle enable pulse
`timescale 1ns/1ps
module fosr_host_sva #(
    parameter AW = 21,
    parameter DW = 16
) (
    // Clock and reset
    input wire clk,
    input wire srst,
    // Software port
    input wire [3:0] reg_addr,
    input wire [31:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    input wire [31:0] reg_rdata,
    // Flash pins
    input wire [AW-1:0] f_addr,
    input wire f_ce_n,
    input wire f_oe_n,
    input wire f_we_n,
    input wire [DW-1:0] f_dq_o,
    input wire f_dq_oe,
    input wire [DW-1:0] f_dq_i
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Enable pulse split in two to keep repeat counts small
    sequence s_low8; (!f_ce_n) [*8]; endsequence
    sequence s_low3; (!f_ce_n) [*3]; endsequence
    // Read-status command byte leaves the pins
    sequence s_cmd; $fell(f_we_n) && f_dq_o == 16'h0070; endsequence
    property p_rdata_zero; !reg_rd |=> reg_rdata == 32'h0; endproperty
    property p_unmapped; reg_rd && reg_addr > 4'h5 |=> reg_rdata == 32'h0; endproperty
    property p_no_fight; !f_oe_n |-> !f_dq_oe; endproperty
    property p_oe_we; !f_we_n |-> f_oe_n; endproperty
    property p_oe_ce; !f_oe_n |-> !f_ce_n; endproperty
    property p_we_hold;
        !f_we_n && $past(!f_we_n) |-> f_dq_oe && $stable(f_dq_o) && $stable(f_addr);
    endproperty
    property p_pulse_len; $fell(f_ce_n) |-> s_low8 ##1 s_low3 ##1 f_ce_n; endproperty
    // Status comes from a fresh read cycle after the command
    property p_cmd_read; s_cmd |-> ##11 f_we_n ##[1:2] !f_oe_n; endproperty
    a_rdata_zero: assert property (p_rdata_zero) else $error("read data not idle");
    a_unmapped: assert property (p_unmapped) else $error("unmapped read nonzero");
    a_no_fight: assert property (p_no_fight) else $error("dq driven in read");
    a_oe_we: assert property (p_oe_we) else $error("oe and we both low");
    a_oe_ce: assert property (p_oe_ce) else $error("oe low without ce");
    a_we_hold: assert property (p_we_hold) else $error("write data moved");
    a_pulse_len: assert property (p_pulse_len) else $error("enable pulse length");
    a_cmd_read: assert property (p_cmd_read) else $error("no read after cmd");
endmodule // fosr_host_sva

bind fosr_host fosr_host_sva #(.AW(AW), .DW(DW)) u_sva (
    .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .f_addr(f_addr),
    .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n), .f_dq_o(f_dq_o),
    .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i)
);

// ---- fosr_host_tb_top.sv ----
// Purpose: self-checking bench for the flash status host
// Assumes: POLL_LIMIT cut to 4, so a poll gives up after 5 reads
// Notes: expected bytes worked out from the status bit layout
`timescale 1ns/1ps
`include "fosr_regs.vh"
module fosr_host_tb_top;
    // ****************************************
    // Signals
    // ****************************************
    reg clk = 1'b0;
    reg srst = 1'b1;
    reg [3:0] reg_addr = 4'h0;
    reg [31:0] reg_wdata = 32'h0;
    reg reg_wr = 1'b0;
    reg reg_rd = 1'b0;
    reg [7:0] dev_stat = 8'h80; // Core status the model reports
    reg [31:0] rv; // Last read word
    wire [31:0] reg_rdata;
    wire [20:0] f_addr;
    wire f_ce_n, f_oe_n, f_we_n, f_dq_oe;
    wire [15:0] f_dq_o, f_dq_i;
    int error_cnt = 0;
    int total_checks = 0;
    fosr_host #(.POLL_LIMIT(4)) DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .f_addr(f_addr), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n), .f_we_n(f_we_n),
        .f_dq_o(f_dq_o), .f_dq_oe(f_dq_oe), .f_dq_i(f_dq_i));
    fosr_flash_model u_flash (.f_dq_o(f_dq_o), .f_ce_n(f_ce_n), .f_oe_n(f_oe_n),
        .f_we_n(f_we_n), .f_dq_i(f_dq_i), .dev_stat(dev_stat));
    initial begin
        forever #4 clk = ~clk;
    end
    // ****************************************
    // Bus tasks
    // ****************************************
    task wr(input [3:0] a, input [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // Data stands only in the cycle after the strobe
    task rd(input [3:0] a, output [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            error_cnt++;
        end
    endtask
    // Bounded wait on the busy bit
    task wait_idle;
        integer i;
        rv = 32'h1;
        for (i = 0; i < 400 && rv[0] !== 1'b0; i++) rd(`FOSR_REG_STAT, rv);
        chk(rv & 32'h1, 32'h0);
    endtask
    task run_op(input [2:0] op);
        wr(`FOSR_REG_CTRL, {29'h0, op});
        wait_idle;
    endtask
    task stop_test;
        if (error_cnt == 0 && total_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // ****************************************
    // Scenarios
    // ****************************************
    task t_reset;
        rd(`FOSR_REG_STAT, rv);
        chk(rv, 32'h0);
        rd(`FOSR_REG_FSTAT, rv);
        chk(rv, 32'h0);
        rd(4'hF, rv);
        chk(rv, 32'h0);
    endtask
    // Each flag alone, then a clean byte to show which stick
    task t_bits;
        integer b;
        reg [7:0] s;
        for (b = 1; b < 7; b++) begin
            s = 8'h80 | (8'h01 << b);
            dev_stat <= s;
            run_op(`FOSR_OP_READ_STAT);
            rd(`FOSR_REG_FSTAT, rv);
            chk(rv, {24'h0, s});
            rd(`FOSR_REG_STAT, rv);
            chk(rv, (s & 8'h3A) ? 32'h4 : 32'h0);
            dev_stat <= 8'h80;
            run_op(`FOSR_OP_READ_STAT);
            rd(`FOSR_REG_FSTAT, rv);
            chk(rv, {24'h0, 8'h80 | (s & 8'h3A)});
            run_op(`FOSR_OP_CLEAR);
        end
        run_op(`FOSR_OP_READ_STAT);
        rd(`FOSR_REG_FSTAT, rv);
        chk(rv, 32'h80);
    endtask
    // Ready arrives on a later re-read of the latch
    task t_poll;
        dev_stat <= 8'h00;
        wr(`FOSR_REG_CTRL, {29'h0, `FOSR_OP_POLL});
        repeat (40) @(posedge clk);
        dev_stat <= 8'h90;
        wait_idle;
        rd(`FOSR_REG_FSTAT, rv);
        chk(rv, 32'h90);
        rd(`FOSR_REG_STAT, rv);
        chk(rv, 32'h4);
        run_op(`FOSR_OP_CLEAR);
    endtask
    // Controller never goes ready: poll gives up, busy suspend flags stay hidden
    task t_timeout;
        dev_stat <= 8'h44;
        run_op(`FOSR_OP_POLL);
        rd(`FOSR_REG_STAT, rv);
        chk(rv, 32'h2);
        rd(`FOSR_REG_FSTAT, rv);
        chk(rv, 32'h0);
    endtask
    // Busy device answers any address with status
    task t_read_any;
        dev_stat <= 8'h44;
        wr(`FOSR_REG_ADDR, 32'h001FFFFF);
        run_op(`FOSR_OP_READ);
        rd(`FOSR_REG_RDATA, rv);
        chk(rv, 32'h45);
        rd(`FOSR_REG_ADDR, rv);
        chk(rv, 32'h001FFFFF);
        chk({11'h0, f_addr}, 32'h001FFFFF);
        wr(`FOSR_REG_DATA, 32'h0000A5C3);
        run_op(`FOSR_OP_WRITE);
        rd(`FOSR_REG_DATA, rv);
        chk(rv, 32'h0000A5C3);
        chk({16'h0, f_dq_o}, 32'h0000A5C3);
    endtask
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        t_reset;
        t_bits;
        t_poll;
        t_timeout;
        t_read_any;
        stop_test;
    end
    // Watchdog well past the expected run of under a thousand cycles
    initial begin
        #400000;
        error_cnt++;
        stop_test;
    end
endmodule // fosr_host_tb_top

// ---- fosr_regs.vh ----
// Purpose: constants for the flash status host controller
// Assumes: 125 MHz clock, 8 ns period
// Notes: software command port offsets and flash status bit positions
`ifndef FOSR_REGS_VH
`define FOSR_REGS_VH

// ****************************************
// Software register offsets
// ****************************************
`define FOSR_REG_CTRL 4'h0
`define FOSR_REG_ADDR 4'h1
`define FOSR_REG_DATA 4'h2
`define FOSR_REG_STAT 4'h3
`define FOSR_REG_FSTAT 4'h4
`define FOSR_REG_RDATA 4'h5

// ****************************************
// Control register codes
// ****************************************
`define FOSR_OP_NONE 3'h0
`define FOSR_OP_READ_STAT 3'h1
`define FOSR_OP_WRITE 3'h2
`define FOSR_OP_READ 3'h3
`define FOSR_OP_POLL 3'h4
`define FOSR_OP_CLEAR 3'h5

// ****************************************
// Flash command bytes
// ****************************************
`define FOSR_CMD_READ_STATUS 16'h0070
`define FOSR_CMD_CLEAR_STATUS 16'h0050

// ****************************************
// Flash status bit positions
// ****************************************
`define FOSR_BIT_READY 7
`define FOSR_BIT_ERASE_SUSP 6
`define FOSR_BIT_ERASE_ERR 5
`define FOSR_BIT_PROG_ERR 4
`define FOSR_BIT_SUPPLY_ERR 3
`define FOSR_BIT_PROG_SUSP 2
`define FOSR_BIT_LOCK_ERR 1
`define FOSR_STATUS_MASK 8'hFE
`define FOSR_ERROR_MASK 8'h3A

// ****************************************
// Timing
// ****************************************
`define FOSR_CLK_NS 8
`define FOSR_PULSE_NS 80
`define FOSR_PULSE_CYC ((`FOSR_PULSE_NS + `FOSR_CLK_NS - 1) / `FOSR_CLK_NS)
`define FOSR_ERASE_SUSP_US 30
`define FOSR_ERASE_SUSP_CYC ((`FOSR_ERASE_SUSP_US * 1000) / `FOSR_CLK_NS)

`endif
